// ===== hw/panel_pkg.sv
// panel_pkg: constants, register map and carrier types for the operator panel controller.
// assumes a single 20 mhz system clock and a classic wishbone slave for software access.
package panel_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int DEBOUNCE_US = 5;
  localparam int DEBOUNCE_CYC = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
  localparam int SLOW_FLASH_MS = 500;
  localparam int SLOW_FLASH_CYC = (CLK_HZ / 1000) * SLOW_FLASH_MS;
  localparam int FAST_FLASH_MS = 125;
  localparam int FAST_FLASH_CYC = (CLK_HZ / 1000) * FAST_FLASH_MS;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] RUN_MASK_A_OFS = 8'h00;
  localparam logic [7:0] RUN_MASK_B_OFS = 8'h04;
  localparam logic [7:0] STOP_MASK_OFS = 8'h08;
  localparam logic [7:0] GROUP_VIS_OFS = 8'h0c;
  localparam logic [7:0] SECOND_ROW_OFS = 8'h10;
  localparam logic [7:0] CONTROL_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam logic [7:0] PARAM_ADDR_OFS = 8'h1c;
  localparam logic [7:0] PARAM_DATA_OFS = 8'h20;
  localparam logic [7:0] PARAM_ATTR_OFS = 8'h24;

  // reset values
  localparam logic [15:0] RUN_MASK_A_RST = 16'h001f;
  localparam logic [15:0] RUN_MASK_B_RST = 16'h0000;
  localparam logic [15:0] STOP_MASK_RST = 16'h0033;
  localparam logic [15:0] GROUP_VIS_RST = 16'h000b; // decimal 11
  localparam logic [15:0] SECOND_ROW_RST = 16'h0000;
  localparam logic [15:0] SECOND_ROW_MAX = 16'h0006;
  localparam logic [15:0] CTL_RST = 16'h0100; // panel source, drive stopped

  // control register fields
  localparam int CTL_SRC_LSB = 0;   // 2 bits: command source
  localparam int CTL_SCOPE_LSB = 2; // 2 bits: stop key scope
  localparam int CTL_TORQUE_BIT = 4;
  localparam int CTL_TUNE_BIT = 5;
  localparam int CTL_FAULT_BIT = 6;
  localparam int CTL_REV_BIT = 7;
  localparam int CTL_STOPPED_BIT = 8; // drive reports stopped

  // parameter attribute fields
  localparam int ATTR_RO_BIT = 0;
  localparam int ATTR_STOPONLY_BIT = 1;

  // command sources
  localparam logic [1:0] SRC_PANEL = 2'h0;
  localparam logic [1:0] SRC_TERMINAL = 2'h1;
  localparam logic [1:0] SRC_COMM = 2'h2;

  // parameter store
  localparam int NUM_GROUPS = 16;   // 0..9 basic, 10..13 enhanced, 14..15 status
  localparam int CODES_PER_GROUP = 16;
  localparam int PARAM_WORDS = NUM_GROUPS * CODES_PER_GROUP;
  localparam logic [3:0] ENH_FIRST = 4'ha;
  localparam logic [3:0] STAT_FIRST = 4'he;
  localparam logic [3:0] LAST_GROUP = 4'hf;
  localparam int DIGITS = 5;

  // unit lamp codes (hz, a, v)
  localparam logic [2:0] UNIT_HZ = 3'h4;
  localparam logic [2:0] UNIT_A = 3'h2;
  localparam logic [2:0] UNIT_V = 3'h1;
  localparam logic [2:0] UNIT_RPM = 3'h6;
  localparam logic [2:0] UNIT_PCT = 3'h3;

  // display sources; first five are the fixed running set
  typedef enum logic [4:0] {
    SEL_RUN_FREQ, SEL_SET_FREQ, SEL_BUS_V, SEL_OUT_V, SEL_OUT_I,
    SEL_OUT_P, SEL_TORQUE, SEL_DI, SEL_PID, SEL_PLC, SEL_PULSE, SEL_NONE
  } disp_sel_e;

  typedef enum logic [1:0] {LVL_RUN, LVL_GROUP, LVL_CODE, LVL_VALUE} menu_level_e;

  typedef struct packed {
    logic menu;
    logic confirm;
    logic shift;
    logic run;
    logic stop;
  } keys_s;

  typedef struct packed {
    logic run;
    logic direction;
    logic tune_torque_fault;
    logic command_source;
    logic [2:0] unit;
  } lamps_s;

  typedef struct packed {
    logic [15:0] run_freq;
    logic [15:0] set_freq;
    logic [15:0] bus_v;
    logic [15:0] out_v;
    logic [15:0] out_i;
    logic [15:0] out_p;
    logic [15:0] torque;
    logic [15:0] di;
    logic [15:0] pid;
    logic [15:0] plc;
    logic [15:0] pulse;
  } monitor_s;
endpackage

// ===== hw/operator_panel_controller.sv
// operator_panel_controller: keys, knob, lamps, five digit display and three level menu.
// assumes keys and knob are synchronous to clk_i; software reaches registers by classic wishbone.
`timescale 1ns/1ns
module operator_panel_controller
  import panel_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // operator side
  input wire keys_s keys_i,
  input wire logic knob_a_i,
  input wire logic knob_b_i,
  input wire monitor_s monitor_i,
  input wire logic [15:0] alarm_code_i,
  input wire logic [3:0] saved_disp_i, // display index restored from nonvolatile store
  output lamps_s lamps_o,
  output logic [DIGITS*4-1:0] digits_o,
  output logic [DIGITS-1:0] digit_blink_o,
  output logic [15:0] second_row_o,
  output logic [3:0] saved_disp_o,
  output logic run_cmd_o,
  output logic stop_cmd_o,
  output logic fault_reset_o
);

  // ---------------------------------------------------------------
  // debounce: keys and both knob phases share one generate loop
  // ---------------------------------------------------------------
  localparam int NIN = 7;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] clean_r, clean_nxt, prev_r, prev_nxt;
  logic [NIN-1:0][15:0] dcnt_r, dcnt_nxt;
  assign raw_in = {knob_b_i, knob_a_i, keys_i};

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_deb
      // a level must hold for the whole window before it is believed
      always_comb begin
        clean_nxt[gi] = clean_r[gi];
        dcnt_nxt[gi] = 16'h0000;
        if (raw_in[gi] != clean_r[gi]) begin
          dcnt_nxt[gi] = dcnt_r[gi] + 16'h0001;
          if (dcnt_r[gi] == 16'(DEBOUNCE_CYC - 1)) begin
            clean_nxt[gi] = raw_in[gi];
            dcnt_nxt[gi] = 16'h0000;
          end
        end
      end
    end
  endgenerate
  assign prev_nxt = clean_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clean_r <= '0;
      prev_r <= '0;
      dcnt_r <= '0;
    end else begin
      clean_r <= clean_nxt;
      prev_r <= prev_nxt;
      dcnt_r <= dcnt_nxt;
    end
  end

  // one-cycle press pulses
  logic [NIN-1:0] rise;
  logic k_stop, k_run, k_shift, k_conf, k_menu, knob_cw, knob_ccw;
  assign rise = clean_r & ~prev_r;
  assign {k_menu, k_conf, k_shift, k_run, k_stop} = rise[4:0];
  // one step per knob detent on phase a rising; phase b gives direction
  assign knob_cw = rise[5] & ~clean_r[6];
  assign knob_ccw = rise[5] & clean_r[6];

  // ---------------------------------------------------------------
  // registers and wishbone slave
  // ---------------------------------------------------------------
  logic [15:0] mask_a_r, mask_a_nxt, mask_b_r, mask_b_nxt, stop_mask_r, stop_mask_nxt;
  logic [15:0] vis_r, vis_nxt, row_r, row_nxt, ctl_r, ctl_nxt;
  logic [7:0] paddr_r, paddr_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic [15:0] pmem [PARAM_WORDS];
  logic [1:0] pattr [PARAM_WORDS];
  logic mem_we, sw_mem_we, sw_attr_we;
  logic [7:0] mem_waddr;
  logic [15:0] mem_wdata;
  logic running, bus_req;
  logic [15:0] status_word;

  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign running = ~ctl_r[CTL_STOPPED_BIT];

  // writes take the low two byte lanes only; a read answers the word
  always_comb begin
    mask_a_nxt = mask_a_r;
    mask_b_nxt = mask_b_r;
    stop_mask_nxt = stop_mask_r;
    vis_nxt = vis_r;
    row_nxt = row_r;
    ctl_nxt = ctl_r;
    paddr_nxt = paddr_r;
    sw_mem_we = 1'b0;
    sw_attr_we = 1'b0;
    ack_nxt = bus_req;
    rdat_nxt = 32'h0000_0000; // unmapped reads zero
    if (bus_req && wb_we_i && wb_sel_i[1:0] == 2'h3) begin
      if (wb_adr_i == RUN_MASK_A_OFS) begin
        mask_a_nxt = wb_dat_i[15:0];
      end else if (wb_adr_i == RUN_MASK_B_OFS) begin
        mask_b_nxt = wb_dat_i[15:0];
      end else if (wb_adr_i == STOP_MASK_OFS) begin
        stop_mask_nxt = wb_dat_i[15:0];
      end else if (wb_adr_i == GROUP_VIS_OFS) begin
        vis_nxt = wb_dat_i[15:0];
      end else if (wb_adr_i == SECOND_ROW_OFS) begin
        if (wb_dat_i[15:0] <= SECOND_ROW_MAX) row_nxt = wb_dat_i[15:0];
      end else if (wb_adr_i == CONTROL_OFS) begin
        ctl_nxt = wb_dat_i[15:0];
      end else if (wb_adr_i == PARAM_ADDR_OFS) begin
        paddr_nxt = wb_dat_i[7:0];
      end else if (wb_adr_i == PARAM_DATA_OFS) begin
        sw_mem_we = 1'b1;
      end else if (wb_adr_i == PARAM_ATTR_OFS) begin
        sw_attr_we = 1'b1;
      end
    end
    if (bus_req && !wb_we_i) begin
      if (wb_adr_i == RUN_MASK_A_OFS) begin
        rdat_nxt = {16'h0000, mask_a_r};
      end else if (wb_adr_i == RUN_MASK_B_OFS) begin
        rdat_nxt = {16'h0000, mask_b_r};
      end else if (wb_adr_i == STOP_MASK_OFS) begin
        rdat_nxt = {16'h0000, stop_mask_r};
      end else if (wb_adr_i == GROUP_VIS_OFS) begin
        rdat_nxt = {16'h0000, vis_r};
      end else if (wb_adr_i == SECOND_ROW_OFS) begin
        rdat_nxt = {16'h0000, row_r};
      end else if (wb_adr_i == CONTROL_OFS) begin
        rdat_nxt = {16'h0000, ctl_r};
      end else if (wb_adr_i == STATUS_OFS) begin
        rdat_nxt = {16'h0000, status_word};
      end else if (wb_adr_i == PARAM_ADDR_OFS) begin
        rdat_nxt = {24'h000000, paddr_r};
      end else if (wb_adr_i == PARAM_DATA_OFS) begin
        rdat_nxt = {16'h0000, pmem[paddr_r]};
      end else if (wb_adr_i == PARAM_ATTR_OFS) begin
        rdat_nxt = {30'h0, pattr[paddr_r]};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_a_r <= RUN_MASK_A_RST;
      mask_b_r <= RUN_MASK_B_RST;
      stop_mask_r <= STOP_MASK_RST;
      vis_r <= GROUP_VIS_RST;
      row_r <= SECOND_ROW_RST;
      ctl_r <= CTL_RST; // panel source, stopped
      paddr_r <= 8'h00;
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      mask_a_r <= mask_a_nxt;
      mask_b_r <= mask_b_nxt;
      stop_mask_r <= stop_mask_nxt;
      vis_r <= vis_nxt;
      row_r <= row_nxt;
      ctl_r <= ctl_nxt;
      paddr_r <= paddr_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ---------------------------------------------------------------
  // menu state machine
  // ---------------------------------------------------------------
  menu_level_e lvl_r, lvl_nxt;
  logic [3:0] grp_r, grp_nxt, code_r, code_nxt, disp_r, disp_nxt;
  logic [2:0] dig_r, dig_nxt;
  logic [15:0] edit_r, edit_nxt, step;
  logic cur_ro, cur_stoponly, editable, enh_vis, stat_vis;
  logic [7:0] cur_addr;
  logic first_r;

  assign cur_addr = {grp_r, code_r};
  assign cur_ro = pattr[cur_addr][ATTR_RO_BIT];
  assign cur_stoponly = pattr[cur_addr][ATTR_STOPONLY_BIT];
  assign editable = ~cur_ro & ~(cur_stoponly & running);
  assign enh_vis = (vis_r / 16'd10) % 16'd10 != 16'd0;
  assign stat_vis = (vis_r % 16'd10) != 16'd0;
  assign step = 16'(16'd1 << (4 * dig_r)); // edit in hex digits

  // next visible group, skipping hidden ones
  function automatic logic [3:0] next_grp(input logic [3:0] g, input logic up,
                                          input logic ev, input logic sv);
    logic [3:0] n;
    n = up ? ((g == LAST_GROUP) ? 4'h0 : g + 4'h1) : ((g == 4'h0) ? LAST_GROUP : g - 4'h1);
    if (!ev && n >= ENH_FIRST && n < STAT_FIRST) n = up ? (sv ? STAT_FIRST : 4'h0) : 4'h9;
    if (!sv && n >= STAT_FIRST) n = up ? 4'h0 : (ev ? STAT_FIRST - 4'h1 : 4'h9);
    return n;
  endfunction

  // active display mask; running set is five fixed values plus mask bits
  logic [15:0] disp_mask;
  always_comb begin
    if (running) begin
      disp_mask = 16'h001f;
      disp_mask[5] = mask_a_r[5];
      disp_mask[6] = mask_a_r[6];
      disp_mask[7] = mask_a_r[7];
      disp_mask[8] = mask_b_r[0];
      disp_mask[9] = mask_b_r[1];
      disp_mask[10] = mask_b_r[2];
    end else begin
      disp_mask = stop_mask_r;
    end
  end

  // next set bit after current display index
  function automatic logic [3:0] next_disp(input logic [3:0] d, input logic [15:0] m);
    logic [3:0] n;
    n = d;
    for (int i = 1; i <= 16; i++) begin
      if (m[4'(d + 4'(i))] && n == d) n = 4'(d + 4'(i));
    end
    return n;
  endfunction

  always_comb begin
    lvl_nxt = lvl_r;
    grp_nxt = grp_r;
    code_nxt = code_r;
    dig_nxt = dig_r;
    edit_nxt = edit_r;
    disp_nxt = disp_r;
    mem_we = 1'b0;
    case (lvl_r)
      LVL_RUN: begin
        if (k_menu) lvl_nxt = LVL_GROUP;
        else if (k_shift) disp_nxt = next_disp(disp_r, disp_mask);
      end
      LVL_GROUP: begin
        if (k_menu) lvl_nxt = LVL_RUN;
        else if (k_conf) lvl_nxt = LVL_CODE;
        else if (knob_cw || knob_ccw) grp_nxt = next_grp(grp_r, knob_cw, enh_vis, stat_vis);
      end
      LVL_CODE: begin
        if (k_menu) lvl_nxt = LVL_GROUP;
        else if (k_conf) begin
          lvl_nxt = LVL_VALUE;
          edit_nxt = pmem[cur_addr];
          dig_nxt = 3'h0;
        end else if (knob_cw) code_nxt = code_r + 4'h1;
        else if (knob_ccw) code_nxt = code_r - 4'h1;
      end
      LVL_VALUE: begin
        if (k_menu) lvl_nxt = LVL_CODE;
        else if (k_conf) begin
          lvl_nxt = LVL_CODE;
          mem_we = editable;
          code_nxt = code_r + 4'h1;
        end else if (k_shift && editable) begin
          dig_nxt = (dig_r == 3'(DIGITS - 2)) ? 3'h0 : dig_r + 3'h1;
        end else if (knob_cw && editable) edit_nxt = edit_r + step;
        else if (knob_ccw && editable) edit_nxt = edit_r - step;
      end
      default: lvl_nxt = LVL_RUN;
    endcase
  end

  assign mem_waddr = sw_mem_we ? paddr_r : cur_addr;
  assign mem_wdata = sw_mem_we ? wb_dat_i[15:0] : edit_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_r <= LVL_RUN;
      grp_r <= 4'h0;
      code_r <= 4'h0;
      dig_r <= 3'h0;
      edit_r <= 16'h0000;
      disp_r <= 4'h0;
    end else begin
      lvl_r <= lvl_nxt;
      grp_r <= grp_nxt;
      code_r <= code_nxt;
      dig_r <= dig_nxt;
      edit_r <= edit_nxt;
      // restored index taken one cycle after release, never under reset
      disp_r <= (prev_r == '0 && lvl_r == LVL_RUN && first_r) ? saved_disp_i : disp_nxt;
    end
  end

  // parameter store: no reset, like the nonvolatile image it mirrors
  always_ff @(posedge clk_i) begin
    if (sw_mem_we || mem_we) pmem[mem_waddr] <= mem_wdata;
    if (sw_attr_we) pattr[paddr_r] <= wb_dat_i[1:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) first_r <= 1'b1;
    else first_r <= 1'b0;
  end
  assign saved_disp_o = disp_r;

  // ---------------------------------------------------------------
  // drive commands
  // ---------------------------------------------------------------
  always_comb begin
    run_cmd_o = k_run && ctl_r[CTL_SRC_LSB +: 2] == SRC_PANEL;
    // scope bit 0 lets stop work, bit 1 lets reset work
    stop_cmd_o = k_stop && running && ctl_r[CTL_SCOPE_LSB];
    fault_reset_o = k_stop && ctl_r[CTL_FAULT_BIT] && ctl_r[CTL_SCOPE_LSB + 1];
  end
  assign status_word = {running, 3'h0, disp_r, 1'b0, dig_r, 1'b0, editable, lvl_r};

  // ---------------------------------------------------------------
  // flash timers and lamps
  // ---------------------------------------------------------------
  logic [23:0] slow_r, slow_nxt, fast_r, fast_nxt;
  logic slow_ph_r, slow_ph_nxt, fast_ph_r, fast_ph_nxt;
  always_comb begin
    slow_nxt = slow_r + 24'h1;
    slow_ph_nxt = slow_ph_r;
    fast_nxt = fast_r + 24'h1;
    fast_ph_nxt = fast_ph_r;
    if (slow_r == 24'(SLOW_FLASH_CYC - 1)) begin
      slow_nxt = 24'h0;
      slow_ph_nxt = ~slow_ph_r;
    end
    if (fast_r == 24'(FAST_FLASH_CYC - 1)) begin
      fast_nxt = 24'h0;
      fast_ph_nxt = ~fast_ph_r;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slow_r <= 24'h0;
      fast_r <= 24'h0;
      slow_ph_r <= 1'b0;
      fast_ph_r <= 1'b0;
    end else begin
      slow_r <= slow_nxt;
      fast_r <= fast_nxt;
      slow_ph_r <= slow_ph_nxt;
      fast_ph_r <= fast_ph_nxt;
    end
  end

  // display value and unit selection
  disp_sel_e sel;
  logic [15:0] shown;
  logic [2:0] unit;
  always_comb begin
    case (disp_r)
      4'h0: sel = SEL_RUN_FREQ;
      4'h1: sel = running ? SEL_SET_FREQ : SEL_BUS_V;
      4'h2: sel = running ? SEL_BUS_V : SEL_DI;
      4'h3: sel = SEL_OUT_V;
      4'h4: sel = SEL_OUT_I;
      4'h5: sel = SEL_OUT_P;
      4'h6: sel = SEL_TORQUE;
      4'h7: sel = SEL_DI;
      4'h8: sel = SEL_PID;
      4'h9: sel = SEL_PLC;
      4'ha: sel = SEL_PULSE;
      default: sel = SEL_NONE;
    endcase
  end
  always_comb begin
    shown = 16'h0000;
    unit = 3'h0;
    case (sel)
      SEL_RUN_FREQ: begin shown = monitor_i.run_freq; unit = UNIT_HZ; end
      SEL_SET_FREQ: begin shown = monitor_i.set_freq; unit = UNIT_HZ; end
      SEL_BUS_V: begin shown = monitor_i.bus_v; unit = UNIT_V; end
      SEL_OUT_V: begin shown = monitor_i.out_v; unit = UNIT_V; end
      SEL_OUT_I: begin shown = monitor_i.out_i; unit = UNIT_A; end
      SEL_OUT_P: shown = monitor_i.out_p;
      SEL_TORQUE: begin shown = monitor_i.torque; unit = UNIT_PCT; end
      SEL_DI: shown = monitor_i.di;
      SEL_PID: shown = monitor_i.pid;
      SEL_PLC: shown = monitor_i.plc;
      SEL_PULSE: begin shown = monitor_i.pulse; unit = UNIT_HZ; end
      default: shown = 16'h0000;
    endcase
  end

  // second row value by selector code
  logic [15:0] row_val;
  always_comb begin
    case (row_r[2:0])
      3'h0: row_val = monitor_i.run_freq;
      3'h1: row_val = monitor_i.set_freq;
      3'h2: row_val = monitor_i.bus_v;
      3'h3: row_val = monitor_i.out_v;
      3'h4: row_val = monitor_i.out_i;
      3'h5: row_val = monitor_i.out_p;
      default: row_val = monitor_i.torque;
    endcase
  end

  // registered outputs
  lamps_s lamps_nxt;
  logic [DIGITS*4-1:0] digits_nxt;
  logic [DIGITS-1:0] blink_nxt;
  always_comb begin
    lamps_nxt.run = running;
    lamps_nxt.direction = ctl_r[CTL_REV_BIT];
    if (ctl_r[CTL_FAULT_BIT]) lamps_nxt.tune_torque_fault = fast_ph_r;
    else if (ctl_r[CTL_TUNE_BIT]) lamps_nxt.tune_torque_fault = slow_ph_r;
    else lamps_nxt.tune_torque_fault = ctl_r[CTL_TORQUE_BIT];
    case (ctl_r[CTL_SRC_LSB +: 2])
      SRC_PANEL: lamps_nxt.command_source = 1'b0;
      SRC_TERMINAL: lamps_nxt.command_source = 1'b1;
      default: lamps_nxt.command_source = slow_ph_r;
    endcase
    lamps_nxt.unit = (lvl_r == LVL_RUN) ? unit : 3'h0;
    blink_nxt = '0;
    if (ctl_r[CTL_FAULT_BIT] && lvl_r == LVL_RUN) begin
      digits_nxt = {4'h0, alarm_code_i};
    end else case (lvl_r)
      LVL_RUN: digits_nxt = {4'h0, shown};
      LVL_GROUP: digits_nxt = {16'h0000, grp_r};
      LVL_CODE: digits_nxt = {8'h00, grp_r, 4'h0, code_r};
      default: begin
        digits_nxt = {4'h0, edit_r};
        if (editable) blink_nxt[dig_r] = 1'b1;
      end
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lamps_o <= '0;
      digits_o <= '0;
      digit_blink_o <= '0;
      second_row_o <= 16'h0000;
    end else begin
      lamps_o <= lamps_nxt;
      digits_o <= digits_nxt;
      digit_blink_o <= blink_nxt;
      second_row_o <= row_val;
    end
  end
endmodule // operator_panel_controller

// ===== verif/panel_checker.sv
// panel_checker: bus and key timing properties on the panel ports.
// assumes one clock and a synchronous active high rst_i.
`timescale 1ns/1ns
module panel_checker
  import panel_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire keys_s keys_i,
  input wire lamps_s lamps_o,
  input wire logic [DIGITS-1:0] digit_blink_o,
  input wire logic run_cmd_o,
  input wire logic stop_cmd_o,
  input wire logic fault_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------
  // properties
  // ----------
  AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  AST_RUN_KEY: assert property (run_cmd_o |-> keys_i.run) else $error("run cmd");
  AST_RUN_PULSE: assert property (run_cmd_o |=> !run_cmd_o) else $error("run twice");
  AST_RUN_HELD: assert property (run_cmd_o |-> $past(keys_i.run, 8))
    else $error("run not debounced");
  AST_STOP_KEY: assert property (stop_cmd_o || fault_reset_o |-> keys_i.stop)
    else $error("stop cmd without key");
  AST_STOP_PULSE: assert property (stop_cmd_o |=> !stop_cmd_o) else $error("stop twice");
  AST_UNIT: assert property (!(lamps_o.unit inside {3'h5, 3'h7})) else $error("unit");
  AST_BLINK: assert property ($onehot0(digit_blink_o)) else $error("blink");
  // main scenarios
  cover property (run_cmd_o);
  cover property (lamps_o.run);
  cover property (lamps_o.command_source);
endmodule // panel_checker

bind operator_panel_controller panel_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .keys_i, .lamps_o, .digit_blink_o, .run_cmd_o, .stop_cmd_o, .fault_reset_o);

// ===== verif/operator_model.sv
// operator_model: a hand on the panel keys.
// assumes keys are sampled on clk_i rising edges.
`timescale 1ns/1ns
module operator_model
  import panel_pkg::*;
(
  input wire logic clk_i,
  output keys_s keys_o,
  output logic knob_a_o,
  output logic knob_b_o
);
  initial begin
    keys_o = '0;
    knob_a_o = 1'b0;
    knob_b_o = 1'b0;
  end
  // hold past the debounce, release as long so no second step is seen
  task automatic press(input int k);
    keys_o[k] <= 1'b1;
    repeat (150) @(posedge clk_i);
    keys_o[k] <= 1'b0;
    repeat (150) @(posedge clk_i);
  endtask
  // one detent; phase b settles first so the direction is clean at the a edge
  task automatic turn(input logic ccw);
    knob_b_o <= ccw;
    repeat (150) @(posedge clk_i);
    knob_a_o <= 1'b1;
    repeat (150) @(posedge clk_i);
    knob_a_o <= 1'b0;
    knob_b_o <= 1'b0;
    repeat (150) @(posedge clk_i);
  endtask
endmodule // operator_model

// ===== verif/operator_panel_controller_bench.sv
// operator_panel_controller_bench: registers, run key, lamps and menu levels.
// assumes the operator model at the keys and a 20 mhz clock.
`timescale 1ns/1ns
module operator_panel_controller_bench
  import panel_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, dat_o;
  logic ack, ka, kb, run_cmd, stop_cmd, frst;
  logic [19:0] digits;
  logic [4:0] blink;
  logic [15:0] row;
  logic [3:0] sdo;
  monitor_s mon = {16'h1000, 16'h1001, 16'h1002, 16'h1003, 16'h1004, 16'h1005,
    16'h1006, 16'h1007, 16'h1008, 16'h1009, 16'h100a};
  int stops = 0;
  int frsts = 0;
  keys_s keys;
  lamps_s lamps;
  int mismatches = 0;
  int total_checks = 0;
  int runs = 0;
  initial forever #25 clk_i = ~clk_i;
  operator_model u_op (.clk_i(clk_i), .keys_o(keys), .knob_a_o(ka), .knob_b_o(kb));
  operator_panel_controller u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .keys_i(keys), .knob_a_i(ka), .knob_b_i(kb),
    .monitor_i(mon), .alarm_code_i(16'h00e1), .saved_disp_i(4'h4), .lamps_o(lamps),
    .digits_o(digits), .digit_blink_o(blink), .second_row_o(row), .saved_disp_o(sdo),
    .run_cmd_o(run_cmd), .stop_cmd_o(stop_cmd), .fault_reset_o(frst));
  // count command pulses, combinational outputs settled at the edge
  always @(posedge clk_i) begin
    if (run_cmd === 1'b1) runs <= runs + 1;
    if (stop_cmd === 1'b1) stops <= stops + 1;
    if (frst === 1'b1) frsts <= frsts + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one classic cycle; the request stands until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      end_of_test();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    check(rdat & m, exp);
  endtask
  task automatic reset_values();
    rd(RUN_MASK_A_OFS, 32'h1f, '1);
    rd(RUN_MASK_B_OFS, 32'h0, '1);
    rd(STOP_MASK_OFS, 32'h33, '1);
    rd(GROUP_VIS_OFS, 32'h0b, '1);
    rd(SECOND_ROW_OFS, 32'h0, '1);
    rd(STATUS_OFS, 32'h400, 32'hf00);
    check(sdo, 32'h4);
    check(row, 32'h1000);
  endtask
  // out of range selector is dropped, top code kept; a hole reads zero
  task automatic second_row();
    bus(1'b1, SECOND_ROW_OFS, 32'h7);
    rd(SECOND_ROW_OFS, 32'h0, '1);
    bus(1'b1, SECOND_ROW_OFS, 32'h6);
    rd(SECOND_ROW_OFS, 32'h6, '1);
    check(row, 32'h1006);
    rd(8'h40, 32'h0, '1);
  endtask
  // stopped screen: restored index 4, then set bits 5 and 0 of the stop mask
  task automatic shift_key();
    check(digits, 32'h1004);
    check(lamps.unit, UNIT_A);
    u_op.press(2);
    check(digits, 32'h1005);
    u_op.press(2);
    check(digits, 32'h1000);
    check(lamps.unit, UNIT_HZ);
  endtask
  // scope bits gate stop and reset; a fault puts the alarm code on the digits
  task automatic stop_key();
    u_op.press(0);
    check(stops, 32'h0);
    bus(1'b1, CONTROL_OFS, 32'h04d);
    u_op.press(0);
    check(stops, 32'h1);
    check(frsts, 32'h1);
    check(digits, 32'he1);
  endtask
  task automatic run_key();
    check({lamps.run, lamps.command_source}, 32'h0);
    u_op.press(1);
    check(runs, 32'h1);
    bus(1'b1, CONTROL_OFS, 32'h101);
    u_op.press(1);
    check({lamps.run, lamps.command_source}, 32'h1);
    check(runs, 32'h1);
    bus(1'b1, CONTROL_OFS, 32'h001);
    repeat (3) @(posedge clk_i);
    check(lamps.run, 32'h1);
  endtask
  task automatic menu_walk();
    bus(1'b1, PARAM_ADDR_OFS, 32'h90);
    bus(1'b1, PARAM_DATA_OFS, 32'h123);
    bus(1'b1, PARAM_ATTR_OFS, 32'h0);
    u_op.press(4);
    rd(STATUS_OFS, 32'h1, 32'h3);
    u_op.turn(1'b0);
    check(digits, 32'h1);
    u_op.turn(1'b1);
    check(digits, 32'h0);
    bus(1'b1, GROUP_VIS_OFS, 32'h0);
    u_op.turn(1'b1);
    check(digits, 32'h9);
    u_op.press(3);
    rd(STATUS_OFS, 32'h2, 32'h3);
    u_op.press(3);
    rd(STATUS_OFS, 32'h7, 32'h7);
    check(digits, 32'h123);
    check(blink, 32'h1);
    u_op.press(4);
    rd(STATUS_OFS, 32'h2, 32'h3);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_values();
    second_row();
    shift_key();
    run_key();
    stop_key();
    menu_walk();
    end_of_test();
  end
endmodule // operator_panel_controller_bench
